/* File: igs_fwd.sv */
// Multicast snooping forwarding control with an APB register slave
`timescale 1ns/100ps
// Summary of operation
// - Global enable switches snooping for whole switch
// - Per-VLAN enable, set singly or by range
// - Only VLAN identifiers 1 to 4094 accepted
// - Unknown group: drop or flood per setting
// - Known group: forward only to member ports
// - Fast removal drops port on v2 leave
// - Fast removal applies to v2 leaves only
// - Fast removal sends no group-specific query
// - Normal leave: send group query, then wait
// - No report within wait: remove port
// - Auto mode: port becomes query port on query
// - Fixed mode: port always a query port
// - Fixed mode: reports and leaves always sent there
// - Edge mode: port never a query port
// - Edge mode: received queries are dropped
// - Joins and leaves go to query ports
// - Global disable overrides every VLAN enable
// - Silence for 400 s flushes all entries
// - Reset clears the global enable
// - Reset: drop unknown, no fast, auto mode
module igs_fwd #(
    parameter int          NPORT   = 6,
    parameter int          NGRP    = 8,
    parameter logic [31:0] AGE_CYC = igs_pkg::AGE_CYC
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [7:0]                 paddr,
    input  wire logic [31:0]                pwdata,
    output logic                            pready,
    output logic [31:0]                     prdata,
    output logic                            pslverr,
    input  wire logic                       ev_valid,
    input  wire logic [2:0]                 ev_kind,
    input  wire logic [$clog2(NPORT)-1:0]   ev_port,
    input  wire logic [igs_pkg::VID_W-1:0]  ev_vlan,
    input  wire logic [igs_pkg::GRP_W-1:0]  ev_group,
    output logic                            fwd_valid,
    output logic [NPORT-1:0]                fwd_mask,
    output logic                            gsq_valid,
    output logic [$clog2(NPORT)-1:0]        gsq_port,
    output logic [igs_pkg::GRP_W-1:0]       gsq_group
);
    localparam int PW = $clog2(NPORT);
    localparam int GW = (NGRP > 1) ? $clog2(NGRP) : 1;
    if (NPORT < 2 || NPORT > 16 || NGRP < 1 || NGRP > 16 ||
            AGE_CYC == 32'h0000_0000) begin : g_bad_param
        $error("igs_fwd: unsupported parameter values");
    end
    typedef struct packed {
        logic                      valid;
        logic [igs_pkg::VID_W-1:0] vlan;
        logic [igs_pkg::GRP_W-1:0] grp;
        logic [NPORT-1:0]          mem;
        logic                      pact;
        logic [PW-1:0]             pport;
        logic [31:0]               pcnt;
    } igs_grp_t;
    typedef struct packed {
        logic                          gen;
        logic                          flood;
        logic [igs_pkg::VID_NUM-1:0]   vlan_en;
        logic [igs_pkg::VID_W-1:0]     vsel;
        logic [NPORT-1:0]              fast;
        logic [2*NPORT-1:0]            mode;
        logic [NPORT-1:0]              qlearn;
        logic [31:0]                   wait_cyc;
        logic [31:0]                   age;
        igs_grp_t [NGRP-1:0]           grp;
        logic                          pready;
        logic [31:0]                   prdata;
        logic                          pslverr;
        logic                          fwd_valid;
        logic [NPORT-1:0]              fwd_mask;
        logic                          gsq_valid;
        logic [PW-1:0]                 gsq_port;
        logic [igs_pkg::GRP_W-1:0]     gsq_group;
    } igs_state_t;
    igs_state_t st;
    igs_state_t next_st;
    // ---------------------------------------------------------------
    // Derived views of the state
    // ---------------------------------------------------------------
    logic [NPORT-1:0] qports;
    logic [NPORT-1:0] edge_mask;
    logic [NPORT-1:0] fixed_mask;
    logic [NPORT-1:0] others;
    logic             snoop;
    logic             hit;
    logic [GW-1:0]    hidx;
    logic             free;
    logic [GW-1:0]    fidx;
    logic [NGRP-1:0]  grp_valid;
    always_comb begin
        others    = ~(NPORT'(1) << ev_port);
        snoop     = st.gen && st.vlan_en[ev_vlan];
        for (int p = 0; p < NPORT; p++) begin
            edge_mask[p]  = (st.mode[2*p +: 2] == igs_pkg::QM_EDGE);
            fixed_mask[p] = (st.mode[2*p +: 2] == igs_pkg::QM_FIXED);
            // Fixed always counts, edge never does, auto once a query is seen
            qports[p]     = fixed_mask[p] || (!edge_mask[p] && st.qlearn[p]);
        end
        hit  = 1'b0;
        hidx = '0;
        free = 1'b0;
        fidx = '0;
        for (int i = 0; i < NGRP; i++) begin
            grp_valid[i] = st.grp[i].valid;
            if (st.grp[i].valid && st.grp[i].vlan == ev_vlan && st.grp[i].grp == ev_group) begin
                hit  = 1'b1;
                hidx = GW'(i);
            end
            if (!st.grp[i].valid && !free) begin
                free = 1'b1;
                fidx = GW'(i);
            end
        end
    end
    // ---------------------------------------------------------------
    // Next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        logic [11:0] lo;
        logic [11:0] hi;
        logic        setup;
        logic        wr;
        lo    = pwdata[igs_pkg::VR_LO +: igs_pkg::VID_W];
        hi    = pwdata[igs_pkg::VR_HI +: igs_pkg::VID_W];
        setup = psel && !penable;
        wr    = psel && penable && st.pready && pwrite;
        next_st           = st;
        next_st.fwd_valid = 1'b0;
        next_st.fwd_mask  = '0;
        next_st.gsq_valid = 1'b0;
        // APB: answer decoded in the setup cycle, ready in the access cycle
        next_st.pready  = setup;
        next_st.pslverr = 1'b0;
        next_st.prdata  = '0;
        if (setup) begin
            if (paddr == igs_pkg::ADDR_CTRL) begin
                next_st.prdata[igs_pkg::CTRL_GEN]   = st.gen;
                next_st.prdata[igs_pkg::CTRL_FLOOD] = st.flood;
            end else if (paddr == igs_pkg::ADDR_VSEL) begin
                next_st.prdata[igs_pkg::VID_W-1:0]  = st.vsel;
                next_st.prdata[igs_pkg::VSEL_EN]    = st.vlan_en[st.vsel];
            end else if (paddr == igs_pkg::ADDR_FAST) begin
                next_st.prdata[NPORT-1:0] = st.fast;
            end else if (paddr == igs_pkg::ADDR_MODE) begin
                next_st.prdata[2*NPORT-1:0] = st.mode;
            end else if (paddr == igs_pkg::ADDR_WAIT) begin
                next_st.prdata = st.wait_cyc;
            end else if (paddr == igs_pkg::ADDR_STAT) begin
                next_st.prdata[NPORT-1:0]                = qports;
                next_st.prdata[igs_pkg::STAT_GRP +: NGRP] = grp_valid;
            end else if (paddr != igs_pkg::ADDR_VRANGE) begin
                next_st.pslverr = 1'b1;
            end
        end
        if (wr) begin
            if (paddr == igs_pkg::ADDR_CTRL) begin
                next_st.gen   = pwdata[igs_pkg::CTRL_GEN];
                next_st.flood = pwdata[igs_pkg::CTRL_FLOOD];
            end else if (paddr == igs_pkg::ADDR_VRANGE) begin
                // A single VLAN is a range with equal ends
                for (int v = igs_pkg::VID_MIN; v <= igs_pkg::VID_MAX; v++) begin
                    if (12'(v) >= lo && 12'(v) <= hi)
                        next_st.vlan_en[v] = pwdata[igs_pkg::VR_VAL];
                end
            end else if (paddr == igs_pkg::ADDR_VSEL) begin
                next_st.vsel = pwdata[igs_pkg::VID_W-1:0];
            end else if (paddr == igs_pkg::ADDR_FAST) begin
                next_st.fast = pwdata[NPORT-1:0];
            end else if (paddr == igs_pkg::ADDR_MODE) begin
                next_st.mode = pwdata[2*NPORT-1:0];
            end else if (paddr == igs_pkg::ADDR_WAIT) begin
                next_st.wait_cyc = pwdata;
            end
        end
        // Leave wait timers run ahead of events so a report this cycle still wins
        for (int i = 0; i < NGRP; i++) begin
            if (st.grp[i].pact) begin
                if (st.grp[i].pcnt == 32'h0000_0000) begin
                    next_st.grp[i].mem[st.grp[i].pport] = 1'b0;
                    next_st.grp[i].pact = 1'b0;
                end else begin
                    next_st.grp[i].pcnt = st.grp[i].pcnt - 32'h0000_0001;
                end
            end
        end
        // Idle timer: any control packet restarts it
        if (ev_valid && ev_kind != igs_pkg::EV_DATA) begin
            next_st.age = '0;
        end else if (st.age >= AGE_CYC - 32'h0000_0001) begin
            next_st.age = '0;
            for (int i = 0; i < NGRP; i++)
                next_st.grp[i].valid = 1'b0;
        end else begin
            next_st.age = st.age + 32'h0000_0001;
        end
        if (ev_valid) begin
            next_st.fwd_valid = 1'b1;
            if (!snoop) begin
                next_st.fwd_mask = others;
            end else begin
                case (ev_kind)
                    igs_pkg::EV_QUERY: begin
                        if (edge_mask[ev_port]) begin
                            next_st.fwd_mask = '0;
                        end else begin
                            next_st.qlearn[ev_port] = 1'b1;
                            next_st.fwd_mask = others;
                        end
                    end
                    igs_pkg::EV_REPORT: begin
                        next_st.fwd_mask = qports & others;
                        if (hit) begin
                            next_st.grp[hidx].mem[ev_port] = 1'b1;
                            if (st.grp[hidx].pport == ev_port)
                                next_st.grp[hidx].pact = 1'b0;
                        end else if (free) begin
                            next_st.grp[fidx]          = '0;
                            next_st.grp[fidx].valid    = 1'b1;
                            next_st.grp[fidx].vlan     = ev_vlan;
                            next_st.grp[fidx].grp      = ev_group;
                            next_st.grp[fidx].mem[ev_port] = 1'b1;
                        end
                    end
                    igs_pkg::EV_LEAVE2, igs_pkg::EV_LEAVE3: begin
                        next_st.fwd_mask = qports & others;
                        if (hit && st.grp[hidx].mem[ev_port]) begin
                            if (st.fast[ev_port] && ev_kind == igs_pkg::EV_LEAVE2) begin
                                // Pruned at once, no query goes out
                                next_st.grp[hidx].mem[ev_port] = 1'b0;
                            end else begin
                                next_st.gsq_valid       = 1'b1;
                                next_st.gsq_port        = ev_port;
                                next_st.gsq_group       = ev_group;
                                next_st.grp[hidx].pact  = 1'b1;
                                next_st.grp[hidx].pport = ev_port;
                                next_st.grp[hidx].pcnt  = st.wait_cyc;
                            end
                        end
                    end
                    default: begin
                        if (hit)
                            next_st.fwd_mask = st.grp[hidx].mem & others;
                        else
                            next_st.fwd_mask = st.flood ? others : '0;
                    end
                endcase
            end
        end
        // Entries with no members and nothing pending free their slot
        for (int i = 0; i < NGRP; i++) begin
            if (next_st.grp[i].mem == '0 && !next_st.grp[i].pact)
                next_st.grp[i].valid = 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st          <= '0;
            st.wait_cyc <= igs_pkg::WAIT_RST;
        end else begin
            st <= next_st;
        end
    end
    assign pready    = st.pready;
    assign prdata    = st.prdata;
    assign pslverr   = st.pslverr;
    assign fwd_valid = st.fwd_valid;
    assign fwd_mask  = st.fwd_mask;
    assign gsq_valid = st.gsq_valid;
    assign gsq_port  = st.gsq_port;
    assign gsq_group = st.gsq_group;
    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire is_data  = ev_valid && ev_kind == igs_pkg::EV_DATA;
    wire is_leave = ev_valid && (ev_kind == igs_pkg::EV_LEAVE2 || ev_kind == igs_pkg::EV_LEAVE3);
    property p_gen_off;
        ev_valid && !st.gen |=> fwd_valid && fwd_mask == $past(others);
    endproperty
    a_gen_off: assert property (p_gen_off) else $error("disabled snoop must flood");
    property p_unknown_drop;
        is_data && snoop && !hit && !st.flood |=> fwd_mask == '0;
    endproperty
    a_unknown_drop: assert property (p_unknown_drop) else $error("unknown not dropped");
    property p_known;
        is_data && snoop && hit |=> fwd_mask == $past(st.grp[hidx].mem & others);
    endproperty
    a_known: assert property (p_known) else $error("known group misforwarded");
    property p_edge_query;
        ev_valid && snoop && ev_kind == igs_pkg::EV_QUERY && edge_mask[ev_port]
            |=> fwd_mask == '0 && !qports[$past(ev_port)];
    endproperty
    a_edge_query: assert property (p_edge_query) else $error("edge query passed");
    property p_qmode;
        (qports & edge_mask) == '0 && (fixed_mask & ~qports) == '0;
    endproperty
    a_qmode: assert property (p_qmode) else $error("query port set wrong");
    property p_fast;
        is_leave && snoop && hit && st.grp[hidx].mem[ev_port] && st.fast[ev_port]
            && ev_kind == igs_pkg::EV_LEAVE2
            |=> !gsq_valid && !st.grp[$past(hidx)].mem[$past(ev_port)];
    endproperty
    a_fast: assert property (p_fast) else $error("fast leave not applied");
    property p_slow;
        is_leave && snoop && hit && st.grp[hidx].mem[ev_port]
            && !(st.fast[ev_port] && ev_kind == igs_pkg::EV_LEAVE2)
            |=> gsq_valid && gsq_port == $past(ev_port) && gsq_group == $past(ev_group);
    endproperty
    a_slow: assert property (p_slow) else $error("group query missing");
    property p_join_fwd;
        ev_valid && snoop && ev_kind == igs_pkg::EV_REPORT |=> fwd_mask == $past(qports & others);
    endproperty
    a_join_fwd: assert property (p_join_fwd) else $error("join misforwarded");
    property p_vid_range;
        !st.vlan_en[0] && !st.vlan_en[igs_pkg::VID_NUM-1];
    endproperty
    a_vid_range: assert property (p_vid_range) else $error("reserved VLAN enabled");
    property p_apb;
        psel && !penable |=> pready ##1 !pready;
    endproperty
    a_apb: assert property (p_apb) else $error("APB ready timing wrong");
    c_fast: cover property (is_leave && snoop && hit && st.fast[ev_port]);
    c_slow: cover property (gsq_valid);
    c_known: cover property (is_data && snoop && hit);
    c_age: cover property (st.age == AGE_CYC - 32'h0000_0001);
endmodule

/* File: igs_pkg.sv */
// Shared constants and types for the multicast snooping forwarder
package igs_pkg;
    // ---------------------------------------------------------------
    // Register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_VRANGE = 8'h04;
    localparam logic [7:0] ADDR_VSEL   = 8'h08;
    localparam logic [7:0] ADDR_FAST   = 8'h0C;
    localparam logic [7:0] ADDR_MODE   = 8'h10;
    localparam logic [7:0] ADDR_WAIT   = 8'h14;
    localparam logic [7:0] ADDR_STAT   = 8'h18;
    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int CTRL_GEN    = 0;
    localparam int CTRL_FLOOD  = 1;
    localparam int VR_LO       = 0;
    localparam int VR_HI       = 12;
    localparam int VR_VAL      = 24;
    localparam int VSEL_EN     = 12;
    localparam int STAT_GRP    = 16;
    // ---------------------------------------------------------------
    // VLAN identifiers and reset values
    // ---------------------------------------------------------------
    localparam int          VID_W    = 12;
    localparam int          VID_NUM  = 4096;
    localparam int          VID_MIN  = 1;
    localparam int          VID_MAX  = 4094;
    localparam int          GRP_W    = 28;
    localparam logic [31:0] WAIT_RST = 32'h0098_9680;
    // ---------------------------------------------------------------
    // Timing
    // ---------------------------------------------------------------
    localparam longint      CLK_HZ   = 10_000_000;
    localparam longint      AGE_S    = 400;
    localparam logic [31:0] AGE_CYC  = 32'(AGE_S * CLK_HZ);
    // ---------------------------------------------------------------
    // Enumerations
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        QM_AUTO  = 2'b00,
        QM_FIXED = 2'b01,
        QM_EDGE  = 2'b11
    } igs_qmode_t;
    typedef enum logic [2:0] {
        EV_DATA   = 3'b000,
        EV_QUERY  = 3'b001,
        EV_REPORT = 3'b011,
        EV_LEAVE2 = 3'b010,
        EV_LEAVE3 = 3'b110
    } igs_kind_t;
endpackage

/* File: igs_port_model.sv */
// Stand-in for the routers and hosts whose packets reach the forwarder
`timescale 1ns/100ps
module igs_port_model #(
    parameter int NPORT = 6
) (
    input  wire logic                       pclk,
    output logic                            ev_valid,
    output logic [2:0]                      ev_kind,
    output logic [$clog2(NPORT)-1:0]        ev_port,
    output logic [igs_pkg::VID_W-1:0]       ev_vlan,
    output logic [igs_pkg::GRP_W-1:0]       ev_group
);
    initial begin
        ev_valid = 1'b0;
        ev_kind  = 3'h0;
        ev_port  = '0;
        ev_vlan  = 12'h000;
        ev_group = 28'h000_0000;
    end
    // One classified packet; fields are scrambled once the edge has taken them
    task automatic send(input logic [2:0] kind, input logic [$clog2(NPORT)-1:0] port,
                        input logic [11:0] vlan, input logic [27:0] grp);
        @(posedge pclk);
        ev_valid <= 1'b1;
        ev_kind  <= kind;
        ev_port  <= port;
        ev_vlan  <= vlan;
        ev_group <= grp;
        @(posedge pclk);
        ev_valid <= 1'b0;
        ev_kind  <= ~kind;
        ev_port  <= ~port;
        ev_vlan  <= ~vlan;
        ev_group <= ~grp;
    endtask
endmodule

/* File: igs_fwd_test.sv */
// Self-checking bench for the multicast snooping forwarder
`timescale 1ns/100ps
module igs_fwd_test;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic        pready, pslverr, ev_valid, fwd_valid, gsq_valid;
    logic [2:0]  ev_kind, ev_port, gsq_port;
    logic [11:0] ev_vlan;
    logic [27:0] ev_group, gsq_group;
    logic [5:0]  fwd_mask;
    int          num_errors = 0;
    int          compares = 0;
    localparam logic [27:0] G1 = 28'h000_0101;
    localparam logic [27:0] G2 = 28'h000_0202;
    // ---------------------------------------------------------------
    // Clock, design and packet source
    // ---------------------------------------------------------------
    always #50 pclk = ~pclk;
    igs_fwd #(.NPORT(6), .NGRP(8), .AGE_CYC(32'h0000_00C8)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .ev_valid(ev_valid), .ev_kind(ev_kind), .ev_port(ev_port), .ev_vlan(ev_vlan),
        .ev_group(ev_group), .fwd_valid(fwd_valid), .fwd_mask(fwd_mask),
        .gsq_valid(gsq_valid), .gsq_port(gsq_port), .gsq_group(gsq_group));
    igs_port_model #(.NPORT(6)) model (
        .pclk(pclk), .ev_valid(ev_valid), .ev_kind(ev_kind), .ev_port(ev_port),
        .ev_vlan(ev_vlan), .ev_group(ev_group));
    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       input logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        check("slave error", {31'h0, pslverr}, {31'h0, err});
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // Send one packet and compare the forwarding answer in the following cycle
    task automatic pkt(input logic [2:0] k, input logic [2:0] p, input logic [27:0] g,
                       input logic [5:0] mask, input logic gsq);
        model.send(k, p, 12'h00A, g);
        #1;
        check("forward valid", {31'h0, fwd_valid}, 32'h0000_0001);
        check("forward mask", {26'h0, fwd_mask}, {26'h0, mask});
        check("query valid", {31'h0, gsq_valid}, {31'h0, gsq});
        if (gsq === 1'b1) check("query target", {1'b0, gsq_port, gsq_group}, {1'b0, p, g});
    endtask
    task automatic results();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge pclk);
        num_errors++;
        results();
    end
    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, igs_pkg::ADDR_CTRL, 32'h0, 1'b0);
        check("ctrl", rd, 32'h0000_0000);
        apb(1'b0, igs_pkg::ADDR_FAST, 32'h0, 1'b0);
        check("fast", rd, 32'h0000_0000);
        apb(1'b0, igs_pkg::ADDR_MODE, 32'h0, 1'b0);
        check("mode", rd, 32'h0000_0000);
        apb(1'b0, igs_pkg::ADDR_WAIT, 32'h0, 1'b0);
        check("wait", rd, igs_pkg::WAIT_RST);
        apb(1'b0, 8'h3C, 32'h0, 1'b1);
        $display("test reset done");
        apb(1'b1, igs_pkg::ADDR_VRANGE, 32'h01FF_F000, 1'b0);
        apb(1'b1, igs_pkg::ADDR_VSEL, 32'h0000_0000, 1'b0);
        apb(1'b0, igs_pkg::ADDR_VSEL, 32'h0, 1'b0);
        check("vlan 0", {31'h0, rd[12]}, 32'h0);
        apb(1'b1, igs_pkg::ADDR_VSEL, 32'h0000_0FFF, 1'b0);
        apb(1'b0, igs_pkg::ADDR_VSEL, 32'h0, 1'b0);
        check("vlan 4095", {31'h0, rd[12]}, 32'h0);
        apb(1'b1, igs_pkg::ADDR_VSEL, 32'h0000_0FFE, 1'b0);
        apb(1'b0, igs_pkg::ADDR_VSEL, 32'h0, 1'b0);
        check("vlan 4094", {31'h0, rd[12]}, 32'h1);
        apb(1'b1, igs_pkg::ADDR_VRANGE, 32'h0000_B00B, 1'b0);
        apb(1'b1, igs_pkg::ADDR_VSEL, 32'h0000_000B, 1'b0);
        apb(1'b0, igs_pkg::ADDR_VSEL, 32'h0, 1'b0);
        check("vlan 11", {31'h0, rd[12]}, 32'h0);
        apb(1'b0, igs_pkg::ADDR_VRANGE, 32'h0, 1'b0);
        check("vrange read", rd, 32'h0000_0000);
        pkt(igs_pkg::EV_DATA, 3'd5, G1, 6'h1F, 1'b0);
        $display("test vlan done");
        apb(1'b1, igs_pkg::ADDR_CTRL, 32'h0000_0001, 1'b0);
        pkt(igs_pkg::EV_DATA, 3'd5, G1, 6'h00, 1'b0);
        apb(1'b1, igs_pkg::ADDR_MODE, 32'h0000_000D, 1'b0);
        apb(1'b1, igs_pkg::ADDR_WAIT, 32'h0000_0014, 1'b0);
        pkt(igs_pkg::EV_QUERY, 3'd1, G1, 6'h00, 1'b0);
        pkt(igs_pkg::EV_QUERY, 3'd4, G1, 6'h2F, 1'b0);
        apb(1'b0, igs_pkg::ADDR_STAT, 32'h0, 1'b0);
        check("query ports", {26'h0, rd[5:0]}, 32'h0000_0011);
        pkt(igs_pkg::EV_REPORT, 3'd2, G1, 6'h11, 1'b0);
        pkt(igs_pkg::EV_REPORT, 3'd3, G1, 6'h11, 1'b0);
        pkt(igs_pkg::EV_DATA, 3'd5, G1, 6'h0C, 1'b0);
        $display("test query done");
        apb(1'b1, igs_pkg::ADDR_FAST, 32'h0000_000C, 1'b0);
        pkt(igs_pkg::EV_LEAVE2, 3'd2, G1, 6'h11, 1'b0);
        pkt(igs_pkg::EV_DATA, 3'd5, G1, 6'h08, 1'b0);
        pkt(igs_pkg::EV_LEAVE3, 3'd3, G1, 6'h11, 1'b1);
        pkt(igs_pkg::EV_DATA, 3'd5, G1, 6'h08, 1'b0);
        repeat (30) @(posedge pclk);
        pkt(igs_pkg::EV_DATA, 3'd5, G1, 6'h00, 1'b0);
        $display("test leave done");
        apb(1'b1, igs_pkg::ADDR_CTRL, 32'h0000_0003, 1'b0);
        pkt(igs_pkg::EV_REPORT, 3'd2, G2, 6'h11, 1'b0);
        pkt(igs_pkg::EV_DATA, 3'd5, G2, 6'h04, 1'b0);
        repeat (220) @(posedge pclk);
        pkt(igs_pkg::EV_DATA, 3'd5, G2, 6'h1F, 1'b0);
        $display("test aging done");
        results();
    end
endmodule
